/* verilog/lesm_map.svh */
// Register offsets, field positions and reset values of the lane error and sync monitor
`ifndef LESM_MAP_SVH
`define LESM_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LESM_ADDR_ERR_READBACK 12'h46B
`define LESM_ADDR_DISPARITY 12'h46D
`define LESM_ADDR_TABLE_MISS 12'h46E
`define LESM_ADDR_STRAY_CTRL 12'h46F
`define LESM_ADDR_SYMBOL_LOCK 12'h470
`define LESM_ADDR_FRAME_LOCK 12'h471
`define LESM_ADDR_CHECKSUM 12'h472
`define LESM_ADDR_IRQ_VECTOR 12'h47A
`define LESM_ADDR_THRESHOLD 12'h47C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LESM_BIT_IRQ_CLEAR 7
`define LESM_BIT_CNT_DISABLE 6
`define LESM_BIT_CNT_CLEAR 5
`define LESM_LANE_PTR_MSB 2
`define LESM_SEL_LANE_MSB 6
`define LESM_SEL_LANE_LSB 4
`define LESM_SEL_TYPE_MSB 1
`define LESM_BIT_FLAG_DISPARITY 7
`define LESM_BIT_FLAG_TABLE_MISS 6
`define LESM_BIT_FLAG_STRAY_CTRL 5
`define LESM_BIT_IRQ_SYMBOL_LOCK 0
`define LESM_BIT_IRQ_FRAME_LOCK 1
`define LESM_BIT_IRQ_CHECKSUM 2
`define LESM_HALF_LANES 4

// ----------------------------------------
// Reset values and counter saturation limit
// ----------------------------------------
`define LESM_RST_THRESHOLD 8'hFF
`define LESM_RST_MASKS 3'h0
`define LESM_RST_BYTE 8'h00
`define LESM_CNT_MAX 8'hFF

`endif

/* verilog/lesm_pkg.sv */
// Types shared by the lane error and sync monitor
package lesm_pkg;

  typedef enum logic [1:0] {
    LESM_CNT_DISPARITY = 2'b00,
    LESM_CNT_TABLE_MISS = 2'b01,
    LESM_CNT_STRAY_CTRL = 2'b10,
    LESM_CNT_NONE = 2'b11
  } lesm_cnt_type_t;

  typedef logic [7:0] lesm_byte_t;
  typedef logic [2:0] lesm_lane_t;
  typedef logic [11:0] lesm_addr_t;

endpackage

/* verilog/lesm_err_bank.sv */
// Eight lane error counters of one error type with threshold flags
`timescale 1ns/10ps
`default_nettype none
`include "lesm_map.svh"

module lesm_err_bank (
  input wire logic core_clk,
  input wire logic rst,
  input wire lesm_pkg::lesm_byte_t err_event,
  input wire lesm_pkg::lesm_byte_t threshold,
  input wire logic ctrl_wr,
  input wire lesm_pkg::lesm_byte_t ctrl_wdata,
  input wire lesm_pkg::lesm_lane_t view_lane,
  output lesm_pkg::lesm_byte_t view_count,
  output lesm_pkg::lesm_byte_t lane_flags
);
  import lesm_pkg::*;

  typedef struct packed {
    logic [7:0][7:0] cnt;
    logic [7:0] off;
    logic [7:0] flag;
  } lesm_bank_state_t;

  lesm_bank_state_t st_ff;
  lesm_bank_state_t nxt_st;
  logic [7:0][7:0] nxt_cnt;
  logic [7:0] nxt_off;
  logic [7:0] nxt_flag;

  // ----------------------------------------
  // Per lane counter
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_lane
      logic hit;
      logic do_clr;
      logic do_dis;
      logic do_irq_clr;
      // Clear strobes act only in the write cycle and are not kept
      assign hit = ctrl_wr && (ctrl_wdata[`LESM_LANE_PTR_MSB:0] == lesm_lane_t'(i));
      assign do_clr = hit && ctrl_wdata[`LESM_BIT_CNT_CLEAR];
      assign do_dis = hit && ctrl_wdata[`LESM_BIT_CNT_DISABLE];
      assign do_irq_clr = hit && ctrl_wdata[`LESM_BIT_IRQ_CLEAR];
      // Disable lasts until reset; no re-enable strobe exists
      assign nxt_off[i] = st_ff.off[i] | do_dis;
      always_comb begin
        if (do_clr) begin
          nxt_cnt[i] = '0;
        end else if (err_event[i] && !nxt_off[i] && st_ff.cnt[i] != `LESM_CNT_MAX) begin
          nxt_cnt[i] = st_ff.cnt[i] + 8'h01;
        end else begin
          nxt_cnt[i] = st_ff.cnt[i];
        end
      end
      // A count at threshold beats an interrupt clear, so zero the count with it to drop the flag
      assign nxt_flag[i] = ((st_ff.cnt[i] >= threshold) & ~do_clr) | (st_ff.flag[i] & ~do_irq_clr);
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;
    nxt_st.cnt = nxt_cnt;
    nxt_st.off = nxt_off;
    nxt_st.flag = nxt_flag;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign view_count = st_ff.cnt[view_lane];
  assign lane_flags = st_ff.flag;

endmodule
`default_nettype wire

/* verilog/lesm_top.sv */
// Lane error and sync monitor: registers, three counter banks, sync flags and resync request
`timescale 1ns/10ps
`default_nettype none
`include "lesm_map.svh"

module lesm_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire lesm_pkg::lesm_addr_t reg_addr,
  input wire logic reg_wr,
  input wire lesm_pkg::lesm_byte_t reg_wdata,
  input wire logic reg_rd,
  output lesm_pkg::lesm_byte_t reg_rdata,
  output logic reg_rvalid,
  input wire lesm_pkg::lesm_byte_t disparity_error_event,
  input wire lesm_pkg::lesm_byte_t table_miss_event,
  input wire lesm_pkg::lesm_byte_t stray_control_event,
  input wire lesm_pkg::lesm_byte_t symbol_lock_lane_flags,
  input wire lesm_pkg::lesm_byte_t frame_lock_lane_flags,
  input wire lesm_pkg::lesm_byte_t config_checksum_ok_flags,
  input wire logic dual_link_mode,
  input wire logic dual_link_view_upper,
  output logic resync_request_output,
  output logic link_restart_pulse,
  output logic irq_n
);
  import lesm_pkg::*;

  typedef struct packed {
    lesm_lane_t counter_lane_select;
    lesm_cnt_type_t counter_type_select;
    lesm_byte_t error_count_threshold;
    logic [2:0] irq_masks;
    lesm_byte_t symbol_prev;
    lesm_byte_t frame_prev;
    lesm_byte_t checksum_prev;
    logic irq_symbol;
    logic irq_frame;
    logic irq_checksum;
    lesm_byte_t rdata;
    logic rvalid;
    logic restart;
    logic resync;
  } lesm_top_state_t;

  lesm_top_state_t st_ff;
  lesm_top_state_t nxt_st;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  logic wr_disp;
  logic wr_miss;
  logic wr_stray;
  logic wr_sym;
  logic wr_frm;
  logic wr_chk;
  assign wr_disp = reg_wr && (reg_addr == `LESM_ADDR_DISPARITY);
  assign wr_miss = reg_wr && (reg_addr == `LESM_ADDR_TABLE_MISS);
  assign wr_stray = reg_wr && (reg_addr == `LESM_ADDR_STRAY_CTRL);
  assign wr_sym = reg_wr && (reg_addr == `LESM_ADDR_SYMBOL_LOCK);
  assign wr_frm = reg_wr && (reg_addr == `LESM_ADDR_FRAME_LOCK);
  assign wr_chk = reg_wr && (reg_addr == `LESM_ADDR_CHECKSUM);

  // ----------------------------------------
  // Configuration and interrupt clear writes
  // ----------------------------------------
  logic wr_select;
  logic wr_threshold;
  logic wr_masks;
  logic clr_symbol_irq;
  logic clr_frame_irq;
  logic clr_checksum_irq;
  assign wr_select = reg_wr && (reg_addr == `LESM_ADDR_ERR_READBACK);
  assign wr_threshold = reg_wr && (reg_addr == `LESM_ADDR_THRESHOLD);
  assign wr_masks = reg_wr && (reg_addr == `LESM_ADDR_IRQ_VECTOR);
  assign clr_symbol_irq = wr_sym && reg_wdata[`LESM_BIT_IRQ_CLEAR];
  assign clr_frame_irq = wr_frm && reg_wdata[`LESM_BIT_IRQ_CLEAR];
  assign clr_checksum_irq = wr_chk && reg_wdata[`LESM_BIT_IRQ_CLEAR];

  // ----------------------------------------
  // Counter banks
  // ----------------------------------------
  lesm_byte_t disp_count;
  lesm_byte_t miss_count;
  lesm_byte_t stray_count;
  lesm_byte_t disparity_threshold_lane_flags;
  lesm_byte_t table_miss_threshold_lane_flags;
  lesm_byte_t stray_control_lane_flags;

  lesm_err_bank u_disp_bank (
    .core_clk(core_clk),
    .rst(rst),
    .err_event(disparity_error_event),
    .threshold(st_ff.error_count_threshold),
    .ctrl_wr(wr_disp),
    .ctrl_wdata(reg_wdata),
    .view_lane(st_ff.counter_lane_select),
    .view_count(disp_count),
    .lane_flags(disparity_threshold_lane_flags)
  );

  lesm_err_bank u_miss_bank (
    .core_clk(core_clk),
    .rst(rst),
    .err_event(table_miss_event),
    .threshold(st_ff.error_count_threshold),
    .ctrl_wr(wr_miss),
    .ctrl_wdata(reg_wdata),
    .view_lane(st_ff.counter_lane_select),
    .view_count(miss_count),
    .lane_flags(table_miss_threshold_lane_flags)
  );

  lesm_err_bank u_stray_bank (
    .core_clk(core_clk),
    .rst(rst),
    .err_event(stray_control_event),
    .threshold(st_ff.error_count_threshold),
    .ctrl_wr(wr_stray),
    .ctrl_wdata(reg_wdata),
    .view_lane(st_ff.counter_lane_select),
    .view_count(stray_count),
    .lane_flags(stray_control_lane_flags)
  );

  // ----------------------------------------
  // Threshold summaries
  // ----------------------------------------
  logic disp_any;
  logic miss_any;
  logic stray_any;
  logic err_irq;
  assign disp_any = |disparity_threshold_lane_flags;
  assign miss_any = |table_miss_threshold_lane_flags;
  assign stray_any = |stray_control_lane_flags;
  // Only masked types may pull the line; the vector bits show regardless of mask
  assign err_irq = (st_ff.irq_masks[2] & disp_any)
                 | (st_ff.irq_masks[1] & miss_any)
                 | (st_ff.irq_masks[0] & stray_any);

  // ----------------------------------------
  // Dual link view
  // ----------------------------------------
  // In dual link mode each link owns four lanes, returned in the low nibble
  function automatic lesm_byte_t link_view(input lesm_byte_t flags, input logic dual, input logic upper);
    lesm_byte_t r;
    r = flags;
    if (dual) begin
      r = upper ? {4'h0, flags[7:`LESM_HALF_LANES]} : {4'h0, flags[`LESM_HALF_LANES-1:0]};
    end
    return r;
  endfunction

  lesm_byte_t disp_view;
  lesm_byte_t miss_view;
  lesm_byte_t stray_view;
  lesm_byte_t frame_view;
  lesm_byte_t checksum_view;
  lesm_byte_t lock_view;
  assign disp_view = link_view(disparity_threshold_lane_flags, dual_link_mode, dual_link_view_upper);
  assign miss_view = link_view(table_miss_threshold_lane_flags, dual_link_mode, dual_link_view_upper);
  assign stray_view = link_view(stray_control_lane_flags, dual_link_mode, dual_link_view_upper);
  assign frame_view = link_view(frame_lock_lane_flags, dual_link_mode, dual_link_view_upper);
  assign checksum_view = link_view(config_checksum_ok_flags, dual_link_mode, dual_link_view_upper);
  assign lock_view = link_view(symbol_lock_lane_flags, dual_link_mode, dual_link_view_upper);

  // ----------------------------------------
  // Sync events
  // ----------------------------------------
  // A lane that was never locked raises no interrupt or restart; only a falling bit counts, but resync follows any unlocked lane
  lesm_byte_t symbol_fall;
  lesm_byte_t frame_fall;
  lesm_byte_t checksum_fall;
  lesm_byte_t lane_unlocked;
  logic symbol_lost;
  logic frame_lost;
  logic checksum_bad;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_sync_lane
      assign symbol_fall[g] = st_ff.symbol_prev[g] & ~symbol_lock_lane_flags[g];
      assign frame_fall[g] = st_ff.frame_prev[g] & ~frame_lock_lane_flags[g];
      assign checksum_fall[g] = st_ff.checksum_prev[g] & ~config_checksum_ok_flags[g];
      assign lane_unlocked[g] = ~symbol_lock_lane_flags[g];
    end
  endgenerate
  assign symbol_lost = |symbol_fall;
  assign frame_lost = |frame_fall;
  assign checksum_bad = |checksum_fall;

  // ----------------------------------------
  // Counter readback
  // ----------------------------------------
  // Lane and type come from the last select write, so a read needs only the offset
  lesm_byte_t count_view;
  always_comb begin
    case (st_ff.counter_type_select)
      LESM_CNT_DISPARITY: begin
        count_view = disp_count;
      end
      LESM_CNT_TABLE_MISS: begin
        count_view = miss_count;
      end
      LESM_CNT_STRAY_CTRL: begin
        count_view = stray_count;
      end
      default: begin
        count_view = `LESM_RST_BYTE;
      end
    endcase
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  lesm_byte_t rd_mux;
  lesm_byte_t sym_view;
  lesm_byte_t vector_view;
  always_comb begin
    sym_view = lock_view;
    // Interrupt flags overlay the live lane bits at their fixed positions
    sym_view[`LESM_BIT_IRQ_SYMBOL_LOCK] = st_ff.irq_symbol;
    sym_view[`LESM_BIT_IRQ_FRAME_LOCK] = st_ff.irq_frame;
    sym_view[`LESM_BIT_IRQ_CHECKSUM] = st_ff.irq_checksum;
    vector_view = `LESM_RST_BYTE;
    vector_view[`LESM_BIT_FLAG_DISPARITY] = disp_any;
    vector_view[`LESM_BIT_FLAG_TABLE_MISS] = miss_any;
    vector_view[`LESM_BIT_FLAG_STRAY_CTRL] = stray_any;
    case (reg_addr)
      `LESM_ADDR_ERR_READBACK: begin
        rd_mux = count_view;
      end
      `LESM_ADDR_DISPARITY: begin
        rd_mux = disp_view;
      end
      `LESM_ADDR_TABLE_MISS: begin
        rd_mux = miss_view;
      end
      `LESM_ADDR_STRAY_CTRL: begin
        rd_mux = stray_view;
      end
      `LESM_ADDR_SYMBOL_LOCK: begin
        rd_mux = sym_view;
      end
      `LESM_ADDR_FRAME_LOCK: begin
        rd_mux = frame_view;
      end
      `LESM_ADDR_CHECKSUM: begin
        rd_mux = checksum_view;
      end
      `LESM_ADDR_IRQ_VECTOR: begin
        rd_mux = vector_view;
      end
      `LESM_ADDR_THRESHOLD: begin
        rd_mux = st_ff.error_count_threshold;
      end
      default: begin
        rd_mux = `LESM_RST_BYTE;
      end
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.symbol_prev = symbol_lock_lane_flags;
    nxt_st.frame_prev = frame_lock_lane_flags;
    nxt_st.checksum_prev = config_checksum_ok_flags;
    if (wr_select) begin
      nxt_st.counter_lane_select = reg_wdata[`LESM_SEL_LANE_MSB:`LESM_SEL_LANE_LSB];
      nxt_st.counter_type_select = lesm_cnt_type_t'(reg_wdata[`LESM_SEL_TYPE_MSB:0]);
    end
    if (wr_threshold) begin
      nxt_st.error_count_threshold = reg_wdata;
    end
    if (wr_masks) begin
      nxt_st.irq_masks = reg_wdata[`LESM_BIT_FLAG_DISPARITY:`LESM_BIT_FLAG_STRAY_CTRL];
    end
    // A loss in the clearing cycle keeps the flag set
    if (symbol_lost) begin
      nxt_st.irq_symbol = 1'b1;
    end else if (clr_symbol_irq) begin
      nxt_st.irq_symbol = 1'b0;
    end
    if (frame_lost) begin
      nxt_st.irq_frame = 1'b1;
    end else if (clr_frame_irq) begin
      nxt_st.irq_frame = 1'b0;
    end
    if (checksum_bad) begin
      nxt_st.irq_checksum = 1'b1;
    end else if (clr_checksum_irq) begin
      nxt_st.irq_checksum = 1'b0;
    end
    nxt_st.resync = |lane_unlocked;
    nxt_st.restart = frame_lost;
    nxt_st.rvalid = reg_rd;
    if (reg_rd) begin
      nxt_st.rdata = rd_mux;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.error_count_threshold <= `LESM_RST_THRESHOLD;
      st_ff.irq_masks <= `LESM_RST_MASKS;
      st_ff.counter_type_select <= LESM_CNT_DISPARITY;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata = st_ff.rdata;
  assign reg_rvalid = st_ff.rvalid;
  assign resync_request_output = st_ff.resync;
  assign link_restart_pulse = st_ff.restart;
  // Threshold flags are level, so the line stays low until the lane flag is cleared or its mask bit is written to zero
  assign irq_n = ~err_irq;

endmodule
`default_nettype wire

/* bench/lesm_tx_model.sv */
// Transmitter stand-in: error pulse bursts on one lane and per lane lock levels
`timescale 1ns/10ps
`default_nettype none
module lesm_tx_model (
  input wire logic core_clk,
  input wire logic go,
  input wire logic [2:0] lane,
  input wire logic [1:0] etype,
  input wire logic [3:0] n,
  input wire logic slow,
  input wire logic [7:0] sym_tgt,
  input wire logic [7:0] frm_tgt,
  input wire logic [7:0] chk_tgt,
  output logic busy,
  output logic [7:0] dis_ev,
  output logic [7:0] nit_ev,
  output logic [7:0] uc_ev,
  output logic [7:0] sym,
  output logic [7:0] frm,
  output logic [7:0] chk
);
  initial begin
    {busy, dis_ev, nit_ev, uc_ev} = '0;
    forever begin
      @(posedge core_clk);
      if (go) begin
        busy <= 1'b1;
        repeat (n) begin
          dis_ev <= (etype == 2'h0) ? (8'h01 << lane) : 8'h00;
          nit_ev <= (etype == 2'h1) ? (8'h01 << lane) : 8'h00;
          uc_ev <= (etype == 2'h2) ? (8'h01 << lane) : 8'h00;
          @(posedge core_clk);
          // A slow sender leaves clean symbols between the bad ones
          if (slow) begin
            {dis_ev, nit_ev, uc_ev} <= '0;
            @(posedge core_clk);
          end
        end
        {dis_ev, nit_ev, uc_ev, busy} <= '0;
      end
    end
  end
  initial begin
    {sym, frm, chk} = '0;
    forever @(posedge core_clk) {sym, frm, chk} <= {sym_tgt, frm_tgt, chk_tgt};
  end
endmodule
`default_nettype wire

/* bench/lesm_top_assertions.sv */
// Port level checks of the lane error and sync monitor
`timescale 1ns/10ps
`default_nettype none
`include "lesm_map.svh"
module lesm_top_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire lesm_pkg::lesm_addr_t reg_addr,
  input wire logic reg_rd,
  input wire lesm_pkg::lesm_byte_t reg_rdata,
  input wire logic reg_rvalid,
  input wire lesm_pkg::lesm_byte_t symbol_lock_lane_flags,
  input wire lesm_pkg::lesm_byte_t frame_lock_lane_flags,
  input wire lesm_pkg::lesm_byte_t config_checksum_ok_flags,
  input wire logic dual_link_mode,
  input wire logic dual_link_view_upper,
  input wire logic resync_request_output,
  input wire logic link_restart_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0] prev_frame_ff;
  logic frame_loss;
  logic [3:0] frame_half;
  // Starts at zero like the design, so no loss is seen out of reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_frame_ff <= 8'h00;
    end else begin
      prev_frame_ff <= frame_lock_lane_flags;
    end
  end
  assign frame_loss = |(prev_frame_ff & ~frame_lock_lane_flags);
  assign frame_half = dual_link_view_upper ? frame_lock_lane_flags[7:4] : frame_lock_lane_flags[3:0];
  a_read_valid_pulse: assert property (reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd)))
    else $error("read strobe not answered by one valid pulse");
  a_rdata_held: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved without a read");
  a_resync_on_loss: assert property ((symbol_lock_lane_flags != 8'hFF) |=> resync_request_output)
    else $error("resync request missing");
  a_resync_idle: assert property ((symbol_lock_lane_flags == 8'hFF) |=> !resync_request_output)
    else $error("resync request without loss");
  a_restart_on_loss: assert property (frame_loss |=> link_restart_pulse)
    else $error("restart pulse missing");
  a_restart_cause: assert property (link_restart_pulse |-> $past(frame_loss))
    else $error("restart pulse without loss");
  a_frame_live_read: assert property (reg_rd && reg_addr == `LESM_ADDR_FRAME_LOCK && !dual_link_mode
    |=> reg_rdata == $past(frame_lock_lane_flags)) else $error("frame lock read wrong");
  a_checksum_read: assert property (reg_rd && reg_addr == `LESM_ADDR_CHECKSUM && !dual_link_mode
    |=> reg_rdata == $past(config_checksum_ok_flags)) else $error("checksum read wrong");
  a_dual_half_read: assert property (reg_rd && reg_addr == `LESM_ADDR_FRAME_LOCK && dual_link_mode
    |=> reg_rdata == {4'h0, $past(frame_half)}) else $error("dual link read wrong");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 12'h400 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind lesm_top lesm_top_assertions u_chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .symbol_lock_lane_flags(symbol_lock_lane_flags),
  .frame_lock_lane_flags(frame_lock_lane_flags), .config_checksum_ok_flags(config_checksum_ok_flags),
  .dual_link_mode(dual_link_mode), .dual_link_view_upper(dual_link_view_upper),
  .resync_request_output(resync_request_output), .link_restart_pulse(link_restart_pulse));
`default_nettype wire

/* bench/tb_serdes_lane_error_sync_monitor.sv */
// Self-checking bench of the lane error and sync monitor
`timescale 1ns/10ps
`default_nettype none
module tb_serdes_lane_error_sync_monitor;
  import lesm_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, dual = 1'b0, upper = 1'b0;
  logic go = 1'b0, slow_c = 1'b0, busy, resync, restart, irq_n, rvalid;
  logic [1:0] et = 2'h0;
  logic [2:0] lane_c = 3'h0;
  lesm_addr_t reg_addr = 12'h000;
  lesm_byte_t wdata = 8'h00, rdata, got, dis_ev, nit_ev, uc_ev, sym, frm, chk_f;
  lesm_byte_t sym_t = 8'h00, frm_t = 8'h00, chk_t = 8'h00;
  int fails = 0, checked = 0, cycles = 0, restarts = 0;
  lesm_top u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(wdata),
    .reg_rd(reg_rd), .reg_rdata(rdata), .reg_rvalid(rvalid), .disparity_error_event(dis_ev),
    .table_miss_event(nit_ev), .stray_control_event(uc_ev), .symbol_lock_lane_flags(sym),
    .frame_lock_lane_flags(frm), .config_checksum_ok_flags(chk_f), .dual_link_mode(dual),
    .dual_link_view_upper(upper), .resync_request_output(resync), .link_restart_pulse(restart), .irq_n(irq_n));
  lesm_tx_model u_tx (.core_clk(core_clk), .go(go), .lane(lane_c), .etype(et), .n(4'h3), .slow(slow_c),
    .sym_tgt(sym_t), .frm_tgt(frm_t), .chk_tgt(chk_t), .busy(busy), .dis_ev(dis_ev), .nit_ev(nit_ev),
    .uc_ev(uc_ev), .sym(sym), .frm(frm), .chk(chk_f));
  always #20 core_clk = ~core_clk;
  // ----------------------------------------
  // Watchdog and shared tasks
  // ----------------------------------------
  always @(posedge core_clk) begin
    cycles++;
    if (restart === 1'b1) restarts++;
    if (cycles == 4000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input lesm_byte_t e, input lesm_byte_t g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input lesm_addr_t a, input lesm_byte_t d);
    reg_addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input lesm_addr_t a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    cmp("rvalid", 8'h01, {7'h00, rvalid});
    got = rdata;
    @(posedge core_clk);
  endtask
  task automatic burst(input logic [2:0] l, input logic [1:0] t, input logic s);
    int k;
    lane_c <= l;
    et <= t;
    slow_c <= s;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    for (k = 0; k < 100 && busy; k++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    lesm_addr_t ra [10] = '{12'h46B, 12'h46D, 12'h46E, 12'h46F, 12'h470, 12'h471, 12'h472, 12'h47A, 12'h47C, 12'h400};
    for (int i = 0; i < 10; i++) begin
      rd(ra[i]);
      cmp("reset value", (ra[i] == 12'h47C) ? 8'hFF : 8'h00, got);
    end
  endtask
  // Each type uses its own lane, so the lane pointer must steer every strobe
  task automatic t_counter(input logic [1:0] t);
    logic [2:0] l;
    lesm_addr_t ca;
    l = 3'(t * 3 + 1);
    ca = 12'h46D + 12'(t);
    wr(12'h47C, 8'h03);
    burst(l, t, t[0]);
    wr(12'h46B, {1'b0, l, 2'h0, t});
    rd(12'h46B); cmp("count", 8'h03, got);
    rd(ca); cmp("lane flags", 8'h01 << l, got);
    wr(12'h47A, 8'h80 >> t);
    cmp("irq low", 8'h00, {7'h00, irq_n});
    wr(ca, 8'h80 | l);
    rd(ca); cmp("flag re-set", 8'h01 << l, got);
    wr(ca, 8'hA0 | l);
    rd(ca); cmp("flag cleared", 8'h00, got);
    rd(12'h46B); cmp("count zeroed", 8'h00, got);
    cmp("irq high", 8'h01, {7'h00, irq_n});
    wr(ca, 8'h40 | l);
    burst(l, t, 1'b0);
    rd(12'h46B); cmp("disabled count", 8'h00, got);
    wr(12'h47A, 8'h00);
  endtask
  task automatic t_sync();
    {sym_t, frm_t, chk_t} <= {3{8'hFF}};
    repeat (3) @(posedge core_clk);
    rd(12'h470); cmp("all locked", 8'hF8, got);
    sym_t <= 8'hF7;
    repeat (3) @(posedge core_clk);
    cmp("resync", 8'h01, {7'h00, resync});
    rd(12'h470); cmp("lock lost irq", 8'hF1, got);
    wr(12'h470, 8'h80);
    rd(12'h470); cmp("lock irq cleared", 8'hF0, got);
    chk_t <= 8'hBF;
    repeat (3) @(posedge core_clk);
    rd(12'h472); cmp("checksum flags", 8'hBF, got);
    rd(12'h470); cmp("checksum irq", 8'hF4, got);
    frm_t <= 8'hEF;
    repeat (3) @(posedge core_clk);
    rd(12'h471); cmp("frame flags", 8'hEF, got);
    cmp("restart pulses", 8'h01, 8'(restarts));
    wr(12'h472, 8'h80);
    rd(12'h470); cmp("frame irq", 8'hF2, got);
    dual <= 1'b1;
    upper <= 1'b1;
    rd(12'h471); cmp("upper link", 8'h0E, got);
    upper <= 1'b0;
    rd(12'h471); cmp("lower link", 8'h0F, got);
    dual <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    for (int t = 0; t < 3; t++) t_counter(2'(t));
    t_sync();
    report_and_stop();
  end
endmodule
`default_nettype wire
